// ===== verif/charger_i2c_control_registers_tb.sv
// Self-checking bench for the charger serial register bank.
`timescale 1ns/100ps
module charger_i2c_control_registers_tb;
   logic                clk;
   logic                rst_n;
   logic                scl;
   logic                mLow;
   logic                sdaOut;
   logic                sdaOe;
   logic                sdaBus;
   logic                boostPin;
   chrg_pkg::chrg_sts_s sts;
   logic                batGood;
   logic                belowRch;
   logic                adpGood;
   chrg_pkg::chrg_ctl_s ctl;
   logic                tmrRst;
   logic                chgEn;
   int                  error_cnt = 0;
   int                  n_tests = 0;
   int                  pulses = 0;
   int                  cyc = 0;
   logic [7:0]          rv;
   logic [2:0]          ak;
   logic [7:0]          x;
   logic [23:0]         rows [8] = '{24'h01a5a5, 24'h025757, 24'h015a5a, 24'h02a8a8,
                                     24'h0312ff, 24'h0634ff, 24'h0900ff, 24'h00002d};
   assign sdaBus = ~(mLow | (sdaOe & ~sdaOut));
   chrg_i2c_master m (.scl(scl), .sdaLow(mLow), .sdaBus(sdaBus));
   chrg_regs dut (.clk(clk), .rst_n(rst_n), .sclClk(scl), .sdaIn(sdaBus), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .boostPinRaw(boostPin), .sts(sts), .batteryGood(batGood),
      .belowRecharge(belowRch), .adapterGood(adpGood), .ctl(ctl), .timerRestart(tmrRst),
      .chargeEnable(chgEn));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (tmrRst === 1'b1) pulses++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk8
   task automatic chk1(input string n, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask : chk1
   task automatic chkCtl(input chrg_pkg::chrg_ctl_s e);
      n_tests++;
      if (ctl !== e) begin
         error_cnt++;
         $display("BAD ctl exp %h got %h", e, ctl);
      end
   endtask : chkCtl
   // Returns the three acknowledge slots; zero means acknowledged.
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
      m.start();
      m.xfer({a, 1'b0}, 1'b1, x, ak[2]);
      m.xfer(r, 1'b1, x, ak[1]);
      m.xfer(d, 1'b1, x, ak[0]);
      m.stop();
   endtask : wr
   task automatic rd(input logic [7:0] r);
      logic k;
      m.start();
      m.xfer(8'hd4, 1'b1, x, k);
      m.xfer(r, 1'b1, x, k);
      m.start();
      m.xfer(8'hd5, 1'b1, x, k);
      m.xfer(8'hff, 1'b1, rv, k);
      m.stop();
   endtask : rd
   initial begin
      rst_n = 1'b0;
      boostPin = 1'b0;
      sts = 6'h2d;
      batGood = 1'b1;
      belowRch = 1'b1;
      adpGood = 1'b1;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      // ----------------------------------------------------------------
      // Table rows: write a register, then read it back
      // ----------------------------------------------------------------
      foreach (rows[i]) begin
         wr(7'h6a, rows[i][23:16], rows[i][15:8]);
         chk8("ack", 8'h00, {5'h00, ak});
         rd(rows[i][23:16]);
         chk8("readback", rows[i][7:0], rv);
      end
      chkCtl(chrg_pkg::chrg_ctl_s'({8'h5a, 8'ha8, 1'b0}));
      // ----------------------------------------------------------------
      // Timer restart, pin sense and boost status
      // ----------------------------------------------------------------
      @(posedge clk) #1 boostPin = 1'b1;
      sts = 6'h1a;
      pulses = 0;
      wr(7'h6a, 8'h00, 8'hc0);
      chk1("timer pulse", 1'b1, pulses == 1);
      rd(8'h00);
      chk8("status", 8'hda, rv);
      // ----------------------------------------------------------------
      // Foreign address is ignored
      // ----------------------------------------------------------------
      wr(7'h6b, 8'h01, 8'h00);
      chk1("nack", 1'b1, ak[2]);
      chkCtl(chrg_pkg::chrg_ctl_s'({8'h5a, 8'ha8, 1'b1}));
      // ----------------------------------------------------------------
      // Two updates in one frame
      // ----------------------------------------------------------------
      m.start();
      m.xfer(8'hd4, 1'b1, x, ak[0]);
      foreach (rows[i]) if (i < 2) begin
         m.xfer(i == 1 ? 8'h01 : 8'h02, 1'b1, x, ak[1]);
         m.xfer(i == 1 ? 8'hfc : 8'h0c, 1'b1, x, ak[2]);
      end
      m.stop();
      chkCtl(chrg_pkg::chrg_ctl_s'({8'hfc, 8'h0c, 1'b1}));
      chk8("pair ack", 8'h00, {5'h00, ak});
      // ----------------------------------------------------------------
      // Charge gating
      // ----------------------------------------------------------------
      chk1("chgEn off", 1'b0, chgEn);
      wr(7'h6a, 8'h01, 8'h30);
      repeat (3) @(posedge clk);
      chk1("chgEn on", 1'b1, chgEn);
      #1 adpGood = 1'b0;
      repeat (3) @(posedge clk);
      chk1("chgEn adapter", 1'b0, chgEn);
      // ----------------------------------------------------------------
      // Second reset restores defaults
      // ----------------------------------------------------------------
      wr(7'h6a, 8'h01, 8'h0e);
      @(posedge clk) #1 rst_n = 1'b0;
      repeat (12) @(posedge clk);
      chk1("sdaOe", 1'b0, sdaOe);
      chk1("tmrRst", 1'b0, tmrRst);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      chkCtl(chrg_pkg::chrg_ctl_s'({8'h30, 8'h0a, 1'b1}));
      report_and_stop();
   end
endmodule : charger_i2c_control_registers_tb

// ===== verif/chrg_i2c_master.sv
// Serial bus master model that drives the charger's serial side.
`timescale 1ns/100ps
module chrg_i2c_master (
   output logic      scl,
   output logic      sdaLow,
   input  wire logic sdaBus
);
   // The clock stands high between frames; the data line has a pull-up.
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // Also serves as a repeated start when called with the clock low.
   task automatic start();
      sdaLow = 1'b0;
      #40 scl = 1'b1;
      #40 sdaLow = 1'b1;
      #40 scl = 1'b0;
   endtask : start
   task automatic stop();
      #20 sdaLow = 1'b1;
      #20 scl = 1'b1;
      #40 sdaLow = 1'b0;
      #80;
   endtask : stop
   // Sampling at the end of the high phase leaves room for the slave's sync delay.
   task automatic bitx(input logic b, output logic r);
      #20 sdaLow = ~b;
      #20 scl = 1'b1;
      #39 r = sdaBus;
      #1 scl = 1'b0;
   endtask : bitx
   // Bytes go MSB first; ackIn high releases the line in the ninth slot.
   task automatic xfer(input logic [7:0] tx, input logic ackIn,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(ackIn, ack);
   endtask : xfer
endmodule : chrg_i2c_master

// ===== verilog/chrg_pkg.sv
// Constants and carrier types for the charger serial register bank.
package chrg_pkg;
   // ----------------------------------------------------------------
   // Bus addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR       = 7'h6a;
   localparam logic [2:0] OFS_STATUS     = 3'h0;
   localparam logic [2:0] OFS_CONTROL    = 3'h1;
   localparam logic [2:0] OFS_REGVOLT    = 3'h2;
   localparam logic [7:0] RD_UNMAPPED    = 8'hff;
   localparam logic [3:0] ACK_SLOT       = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         TMR_BIT        = 7;
   localparam int         STATEN_BIT     = 6;
   localparam logic       STATEN_RST     = 1'b1;
   localparam logic [7:0] CONTROL_RST    = 8'h30;
   localparam logic [7:0] REGVOLT_RST    = 8'h0a;

   typedef enum logic [2:0] {
      CHRG_IDLE    = 3'b000,
      CHRG_DEVADDR = 3'b001,
      CHRG_REGADDR = 3'b010,
      CHRG_WRDATA  = 3'b011,
      CHRG_RDDATA  = 3'b100,
      CHRG_WAIT    = 3'b101
   } chrg_state_e;

   // Control fields presented to the analog side.
   typedef struct packed {
      logic [1:0] inputLimit;
      logic [1:0] weakBatteryLevel;
      logic       cutoffAllow;
      logic       chargerOff;
      logic       highImpedanceSelect;
      logic       boostSelect;
      logic [5:0] batteryRegulationLevel;
      logic       boostPinPolarity;
      logic       boostPinGate;
      logic       statPinEnable;
   } chrg_ctl_s;

   // Status reported by the analog side.
   typedef struct packed {
      logic [1:0] chargeStateCode;
      logic       boostActive;
      logic [2:0] faultCode;
   } chrg_sts_s;
endpackage : chrg_pkg

// ===== verilog/chrg_regs.sv
// Serial-bus slave and control register bank of the charger.
`timescale 1ns/100ps
// Functional notes
// - Register address byte: upper five zero, low three select
// - Five byte registers, four writable, one read only; only reg0 to reg2 are implemented here
// - Charge only with good battery and adapter
// - Reg0 bit7 write restarts timer; read shows pin
// - Reg0 bit6 enables indicator pin, default one
// - Reg0 bits5:4 report charge state code
// - Reg0 bit3 reads one in boost mode
// - Charge mode fault cause in reg0 bits2:0
// - Boost mode fault cause in reg0 bits2:0
// - Reg1 bits7:6 select input current limit
// - Reg1 bits5:4 weak battery level, default 11
// - Reg1 bit3 enables termination, default zero
// - Reg1 bit2 set disables the charger
// - Reg1 bit1 selects high impedance mode
// - Reg1 bit0 selects boost, default charger
// - Reg2 bits7:2 regulation voltage, default 3.54 V
// - Reg2 bit1 sets boost pin active level
// - Reg2 bit0 gates boost pin, default zero
// - Write commits at falling edge ending acknowledge
// - Further address and data pairs until stop
// - Unimplemented register reads return FFh
// - Answer only seven-bit address 1101010
module chrg_regs (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              sclClk,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOe,
   input  wire logic              boostPinRaw,
   input  wire chrg_pkg::chrg_sts_s sts,
   input  wire logic              batteryGood,
   input  wire logic              belowRecharge,
   input  wire logic              adapterGood,
   output chrg_pkg::chrg_ctl_s    ctl,
   output logic                   timerRestart,
   output logic                   chargeEnable
);
   // ----------------------------------------------------------------
   // Link domain capture
   // ----------------------------------------------------------------
   // The data bit is caught on the serial clock itself. It stays stable
   // for a whole clock period, so the system side reads it once its own
   // synchronised copy of the clock has risen; no reset is needed here.
   logic sampleQ;
   always_ff @(posedge sclClk) begin
      sampleQ <= sdaIn;
   end

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sclSync_q, sdaSync_q, pinSync_q;
   logic       sclLast_q, sdaLast_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclSync_q <= 2'h3;
         sdaSync_q <= 2'h3;
         pinSync_q <= 2'h0;
         sclLast_q <= 1'b1;
         sdaLast_q <= 1'b1;
      end else begin
         sclSync_q <= {sclSync_q[0], sclClk};
         sdaSync_q <= {sdaSync_q[0], sdaIn};
         pinSync_q <= {pinSync_q[0], boostPinRaw};
         sclLast_q <= sclSync_q[1];
         sdaLast_q <= sdaSync_q[1];
      end
   end

   logic sclRise, sclFall, startSeen, stopSeen;
   assign sclRise   = sclSync_q[1] & ~sclLast_q;
   assign sclFall   = ~sclSync_q[1] & sclLast_q;
   assign startSeen = sclSync_q[1] & sclLast_q & sdaLast_q & ~sdaSync_q[1];
   assign stopSeen  = sclSync_q[1] & sclLast_q & ~sdaLast_q & sdaSync_q[1];

   // ----------------------------------------------------------------
   // Frame alignment
   // ----------------------------------------------------------------
   // The clock fall that closes a start condition carries no bit, so only
   // falls that follow a rise of the current frame move the bit counter.
   logic riseSeen_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         riseSeen_q <= 1'b0;
      end else if (startSeen) begin
         riseSeen_q <= 1'b0;
      end else if (sclRise) begin
         riseSeen_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------
   chrg_pkg::chrg_state_e state_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q, tx_q;
   logic [2:0] ptr_q;
   logic       ptrValid_q, readDir_q, masterNack_q, wrPending_q, commit;
   logic [7:0] rdByte;

   // Status register image: pin level, enable, state, boost, cause.
   always_comb begin
      rdByte = chrg_pkg::RD_UNMAPPED;
      if (ptrValid_q && ptr_q == chrg_pkg::OFS_STATUS) begin
         rdByte = {pinSync_q[1], ctl.statPinEnable, sts.chargeStateCode,
                   sts.boostActive, sts.faultCode};
      end else if (ptrValid_q && ptr_q == chrg_pkg::OFS_CONTROL) begin
         rdByte = {ctl.inputLimit, ctl.weakBatteryLevel, ctl.cutoffAllow,
                   ctl.chargerOff, ctl.highImpedanceSelect, ctl.boostSelect};
      end else if (ptrValid_q && ptr_q == chrg_pkg::OFS_REGVOLT) begin
         rdByte = {ctl.batteryRegulationLevel, ctl.boostPinPolarity, ctl.boostPinGate};
      end
   end

   assign commit = sclFall && bitCnt_q == chrg_pkg::ACK_SLOT && wrPending_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q      <= chrg_pkg::CHRG_IDLE;
         bitCnt_q     <= 4'h0;
         shift_q      <= 8'h00;
         tx_q         <= 8'h00;
         ptr_q        <= 3'h0;
         ptrValid_q   <= 1'b0;
         readDir_q    <= 1'b0;
         masterNack_q <= 1'b0;
         wrPending_q  <= 1'b0;
         sdaOe        <= 1'b0;
      end else if (stopSeen) begin
         state_q     <= chrg_pkg::CHRG_IDLE;
         sdaOe       <= 1'b0;
         wrPending_q <= 1'b0;
      end else if (startSeen) begin
         state_q     <= chrg_pkg::CHRG_DEVADDR;
         bitCnt_q    <= 4'h0;
         sdaOe       <= 1'b0;
         wrPending_q <= 1'b0;
      end else if (state_q != chrg_pkg::CHRG_IDLE && state_q != chrg_pkg::CHRG_WAIT) begin
         if (sclRise) begin
            if (bitCnt_q < chrg_pkg::ACK_SLOT) begin
               shift_q <= {shift_q[6:0], sampleQ};
            end else begin
               masterNack_q <= sampleQ;
            end
         end else if (sclFall && riseSeen_q) begin
            if (bitCnt_q == chrg_pkg::LAST_DATA_BIT) begin
               bitCnt_q <= chrg_pkg::ACK_SLOT;
               sdaOe    <= 1'b0;
               case (state_q)
                  chrg_pkg::CHRG_DEVADDR: begin
                     if (shift_q[7:1] == chrg_pkg::DEV_ADDR) begin
                        sdaOe     <= 1'b1;
                        readDir_q <= shift_q[0];
                     end else begin
                        state_q <= chrg_pkg::CHRG_WAIT;
                     end
                  end
                  chrg_pkg::CHRG_REGADDR: begin
                     sdaOe      <= 1'b1;
                     ptr_q      <= shift_q[2:0];
                     ptrValid_q <= shift_q[7:3] == 5'h00;
                  end
                  chrg_pkg::CHRG_WRDATA: begin
                     sdaOe       <= 1'b1;
                     wrPending_q <= 1'b1;
                  end
                  default: begin
                     sdaOe <= 1'b0;
                  end
               endcase
            end else if (bitCnt_q == chrg_pkg::ACK_SLOT) begin
               bitCnt_q    <= 4'h0;
               sdaOe       <= 1'b0;
               wrPending_q <= 1'b0;
               case (state_q)
                  chrg_pkg::CHRG_DEVADDR: begin
                     if (readDir_q) begin
                        state_q <= chrg_pkg::CHRG_RDDATA;
                        tx_q    <= {rdByte[6:0], 1'b0};
                        sdaOe   <= ~rdByte[7];
                     end else begin
                        state_q <= chrg_pkg::CHRG_REGADDR;
                     end
                  end
                  chrg_pkg::CHRG_REGADDR: begin
                     state_q <= chrg_pkg::CHRG_WRDATA;
                  end
                  chrg_pkg::CHRG_WRDATA: begin
                     state_q <= chrg_pkg::CHRG_REGADDR;
                  end
                  chrg_pkg::CHRG_RDDATA: begin
                     if (masterNack_q) begin
                        state_q <= chrg_pkg::CHRG_WAIT;
                     end else begin
                        tx_q  <= {rdByte[6:0], 1'b0};
                        sdaOe <= ~rdByte[7];
                     end
                  end
                  default: begin
                     state_q <= chrg_pkg::CHRG_WAIT;
                  end
               endcase
            end else begin
               bitCnt_q <= bitCnt_q + 4'h1;
               if (state_q == chrg_pkg::CHRG_RDDATA) begin
                  sdaOe <= ~tx_q[7];
                  tx_q  <= {tx_q[6:0], 1'b0};
               end
            end
         end
      end
   end

   // Open drain: only ever pulls low.
   always_ff @(posedge clk) begin
      sdaOut <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   // Writes to unmapped or malformed addresses are dropped silently.
   logic wrHit;
   assign wrHit = commit && ptrValid_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl.statPinEnable <= chrg_pkg::STATEN_RST;
         {ctl.inputLimit, ctl.weakBatteryLevel, ctl.cutoffAllow, ctl.chargerOff,
          ctl.highImpedanceSelect, ctl.boostSelect} <= chrg_pkg::CONTROL_RST;
         {ctl.batteryRegulationLevel, ctl.boostPinPolarity,
          ctl.boostPinGate} <= chrg_pkg::REGVOLT_RST;
      end else if (wrHit) begin
         if (ptr_q == chrg_pkg::OFS_STATUS) begin
            ctl.statPinEnable <= shift_q[chrg_pkg::STATEN_BIT];
         end else if (ptr_q == chrg_pkg::OFS_CONTROL) begin
            {ctl.inputLimit, ctl.weakBatteryLevel, ctl.cutoffAllow, ctl.chargerOff,
             ctl.highImpedanceSelect, ctl.boostSelect} <= shift_q;
         end else if (ptr_q == chrg_pkg::OFS_REGVOLT) begin
            {ctl.batteryRegulationLevel, ctl.boostPinPolarity,
             ctl.boostPinGate} <= shift_q;
         end
      end
   end

   // The restart bit is never stored, so it always reads back as the pin.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timerRestart <= 1'b0;
      end else begin
         timerRestart <= wrHit && ptr_q == chrg_pkg::OFS_STATUS
                         && shift_q[chrg_pkg::TMR_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Charge gate
   // ----------------------------------------------------------------
   // Boost and high impedance also stop charging; the stage cannot serve both.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chargeEnable <= 1'b0;
      end else begin
         chargeEnable <= batteryGood & belowRecharge & adapterGood & ~ctl.chargerOff
                         & ~ctl.highImpedanceSelect & ~ctl.boostSelect;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_restart_pulse: assert property (timerRestart |=> !timerRestart)
      else $error("timer restart longer than one cycle");
   a_restart_cause: assert property (timerRestart |-> $past(commit))
      else $error("timer restart without a committed write");
   a_ctl_only_commit: assert property (!commit |=> $stable(ctl))
      else $error("control changed without a commit");
   a_commit_at_fall: assert property (commit |-> sclFall && bitCnt_q == chrg_pkg::ACK_SLOT)
      else $error("commit outside the acknowledge falling edge");
   a_addr_nack: assert property (state_q == chrg_pkg::CHRG_DEVADDR && sclFall
      && bitCnt_q == chrg_pkg::LAST_DATA_BIT && shift_q[7:1] != chrg_pkg::DEV_ADDR
      |=> !sdaOe)
      else $error("acknowledged a foreign address");
   a_unmapped_ff: assert property (!ptrValid_q || ptr_q > chrg_pkg::OFS_REGVOLT
      |-> rdByte == chrg_pkg::RD_UNMAPPED)
      else $error("unmapped read is not FFh");
   a_status_pin: assert property (ptrValid_q && ptr_q == chrg_pkg::OFS_STATUS
      |-> rdByte[chrg_pkg::TMR_BIT] == pinSync_q[1] && rdByte[5:0] == sts)
      else $error("status image wrong");
   a_charge_gate: assert property (ctl.chargerOff |=> !chargeEnable)
      else $error("charging while disabled");
   a_data_to_addr: assert property (state_q == chrg_pkg::CHRG_WRDATA && sclFall
      && bitCnt_q == chrg_pkg::ACK_SLOT && !stopSeen && !startSeen
      |=> state_q == chrg_pkg::CHRG_REGADDR)
      else $error("no return to address after data");
   a_idle_quiet: assert property (state_q == chrg_pkg::CHRG_IDLE ##1
      state_q == chrg_pkg::CHRG_IDLE |-> !sdaOe)
      else $error("driving the line while idle");


   a_count_bound: assert property (bitCnt_q <= chrg_pkg::ACK_SLOT)
      else $error("bit counter beyond the acknowledge slot");
   a_first_fall: assert property (state_q == chrg_pkg::CHRG_DEVADDR && sclFall
      && !riseSeen_q |=> bitCnt_q == 4'h0)
      else $error("start fall counted as a bit");
   a_start_resets: assert property (startSeen |=> state_q == chrg_pkg::CHRG_DEVADDR
      && bitCnt_q == 4'h0)
      else $error("start did not rearm the address phase");
   a_stop_idle: assert property (stopSeen
      |=> state_q == chrg_pkg::CHRG_IDLE && !sdaOe)
      else $error("stop did not release the bus");
   a_wait_quiet: assert property (state_q == chrg_pkg::CHRG_WAIT |-> !sdaOe)
      else $error("driving the line while waiting");

   a_addr_ack: assert property (state_q == chrg_pkg::CHRG_DEVADDR && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::LAST_DATA_BIT
      && shift_q[7:1] == chrg_pkg::DEV_ADDR |=> sdaOe)
      else $error("own address not acknowledged");
   a_write_enter: assert property (state_q == chrg_pkg::CHRG_DEVADDR && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::ACK_SLOT && !readDir_q
      |=> state_q == chrg_pkg::CHRG_REGADDR && !sdaOe)
      else $error("write frame did not move to the register address");
   a_read_enter: assert property (state_q == chrg_pkg::CHRG_DEVADDR && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::ACK_SLOT && readDir_q
      |=> state_q == chrg_pkg::CHRG_RDDATA)
      else $error("read frame did not move to the data phase");
   a_reg_ack: assert property (state_q == chrg_pkg::CHRG_REGADDR && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::LAST_DATA_BIT |=> sdaOe)
      else $error("register address byte not acknowledged");
   a_ptr_invalid: assert property (state_q == chrg_pkg::CHRG_REGADDR && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::LAST_DATA_BIT && shift_q[7:3] != 5'h00
      |=> !ptrValid_q)
      else $error("malformed register address accepted");
   a_reg_release: assert property (state_q == chrg_pkg::CHRG_REGADDR && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::ACK_SLOT
      |=> state_q == chrg_pkg::CHRG_WRDATA && !sdaOe)
      else $error("register address not followed by data phase");
   a_data_ack: assert property (state_q == chrg_pkg::CHRG_WRDATA && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::LAST_DATA_BIT |=> sdaOe && wrPending_q)
      else $error("data byte not acknowledged");
   a_read_release: assert property (state_q == chrg_pkg::CHRG_RDDATA && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::LAST_DATA_BIT |=> !sdaOe)
      else $error("line held in the host acknowledge slot");
   a_nack_ends: assert property (state_q == chrg_pkg::CHRG_RDDATA && sclFall
      && riseSeen_q && bitCnt_q == chrg_pkg::ACK_SLOT && masterNack_q
      |=> state_q == chrg_pkg::CHRG_WAIT && !sdaOe)
      else $error("read went on after a host refusal");

   a_drop_invalid: assert property (commit
      && (!ptrValid_q || ptr_q > chrg_pkg::OFS_REGVOLT) |=> $stable(ctl))
      else $error("write to an absent register changed control");
   a_restart_set: assert property (wrHit && ptr_q == chrg_pkg::OFS_STATUS
      && shift_q[chrg_pkg::TMR_BIT] |=> timerRestart)
      else $error("timer restart write lost");
   a_restart_other: assert property (commit && ptr_q != chrg_pkg::OFS_STATUS
      |=> !timerRestart)
      else $error("timer restart from another register");
   a_charge_qual: assert property (!(batteryGood && belowRecharge && adapterGood)
      |=> !chargeEnable)
      else $error("charging without battery and adapter");
   a_mode_block: assert property (ctl.boostSelect || ctl.highImpedanceSelect
      |=> !chargeEnable)
      else $error("charging in boost or high impedance mode");

   c_write: cover property (commit && ptr_q == chrg_pkg::OFS_CONTROL);
   c_restart: cover property (timerRestart);
   c_read: cover property (state_q == chrg_pkg::CHRG_RDDATA && sclFall);
   c_pair: cover property (commit ##[1:400] commit);
   c_refused: cover property (state_q == chrg_pkg::CHRG_WAIT);
endmodule : chrg_regs
